// ---- src/bcc_cfg_pkg.sv ----
package bcc_cfg_pkg;

   // ------------------------------------------------------------
   // Register offsets
   // ------------------------------------------------------------
   localparam logic [7:0] OFF_BACK_CHANNEL_CONFIG = 8'h58;
   localparam logic [7:0] OFF_DATAPATH_CONTROL_ONE = 8'h59;
   localparam logic [7:0] OFF_DATAPATH_CONTROL_TWO = 8'h5A;
   localparam logic [7:0] OFF_REMOTE_DEVICE_IDENTITY = 8'h5B;
   localparam logic [7:0] OFF_REMOTE_ALIAS_DECODE = 8'h5C;
   localparam logic [7:0] OFF_FAR_TARGET_ADDRESS_0 = 8'h5D;

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int BIT_PASS_ALL = 7;
   localparam int BIT_PASS_MATCH = 6;
   localparam int BIT_ACK_ALL = 5;
   localparam int BIT_FORCE_ON = 4;
   localparam int BIT_CRC_EN = 3;
   localparam int RATE_MSB = 2;
   localparam int BIT_BLOCK_LOAD = 7;
   localparam int GPIO_MSB = 1;
   localparam int ADDR_MSB = 7;
   localparam int ADDR_LSB = 1;
   localparam int BIT_HOLD_ID = 0;
   localparam int BIT_AUTOACK = 0;
   localparam int BIT_RW = 0;

   // ------------------------------------------------------------
   // Values after reset
   // ------------------------------------------------------------
   localparam logic RST_PASS_ALL = 1'b0;
   localparam logic RST_PASS_MATCH = 1'b0;
   localparam logic RST_ACK_ALL = 1'b0;
   localparam logic RST_FORCE_ON = 1'b1;
   localparam logic RST_CRC_EN = 1'b1;
   localparam logic [2:0] RST_RATE = 3'h0;
   localparam logic RST_FLAG = 1'b0;
   localparam logic [1:0] RST_GPIO = 2'h0;
   localparam logic [6:0] RST_ADDR7 = 7'h00;
   localparam logic [7:0] RST_RDATA = 8'h00;

   // ------------------------------------------------------------
   // Return link rate codes
   // ------------------------------------------------------------
   localparam logic [2:0] RATE_CODE_2M5 = 3'h0;
   localparam logic [2:0] RATE_CODE_10M = 3'h2;
   localparam logic [2:0] RATE_CODE_25M = 3'h5;
   localparam logic [2:0] RATE_CODE_50M = 3'h6;
   localparam logic [2:0] RATE_CODE_100M = 3'h7;

   typedef enum logic [5:0] {
      RATE_2M5 = 6'h01,
      RATE_10M = 6'h02,
      RATE_25M = 6'h04,
      RATE_50M = 6'h08,
      RATE_100M = 6'h10,
      RATE_RESERVED = 6'h20
   } rate_t;

   function automatic rate_t decode_rate(input logic [2:0] code);
      unique case (code)
         RATE_CODE_2M5: decode_rate = RATE_2M5;
         RATE_CODE_10M: decode_rate = RATE_10M;
         RATE_CODE_25M: decode_rate = RATE_25M;
         RATE_CODE_50M: decode_rate = RATE_50M;
         RATE_CODE_100M: decode_rate = RATE_100M;
         default: decode_rate = RATE_RESERVED;
      endcase
   endfunction

endpackage

// ---- src/fwd_cfg_if.sv ----
`timescale 1ns/10ps
`default_nettype none

interface fwd_cfg_if;
   logic passAll;
   logic passMatch;
   logic ackAll;
   logic remoteAutoAck;
   logic [6:0] aliasAddr;
   logic [6:0] targetAddr;
   modport src (output passAll, passMatch, ackAll, remoteAutoAck, aliasAddr, targetAddr);
   modport sink (input passAll, passMatch, ackAll, remoteAutoAck, aliasAddr, targetAddr);
endinterface

`default_nettype wire

// ---- src/addr_forward_decode.sv ----
`timescale 1ns/10ps
`default_nettype none

module addr_forward_decode (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Configuration
   fwd_cfg_if.sink cfg,
   // Incoming address byte
   input wire logic txnValid,
   input wire logic [7:0] txnAddr,
   // Forward decision
   output logic fwdValid,
   output logic [7:0] fwdAddr,
   output logic localAck,
   output logic aliasHit
);

   logic match;
   logic isWrite;

   // A zero alias never matches, so the far target is unreachable
   assign match = (cfg.aliasAddr != bcc_cfg_pkg::RST_ADDR7) &&
                  (txnAddr[bcc_cfg_pkg::ADDR_MSB:bcc_cfg_pkg::ADDR_LSB] == cfg.aliasAddr);
   assign isWrite = !txnAddr[bcc_cfg_pkg::BIT_RW];

   always_ff @(posedge clk) begin
      if (rst) begin
         fwdValid <= 1'b0;
         fwdAddr <= bcc_cfg_pkg::RST_RDATA;
         localAck <= 1'b0;
         aliasHit <= 1'b0;
      end else begin
         fwdValid <= txnValid && (cfg.passAll || (cfg.passMatch && match));
         localAck <= txnValid && isWrite && (cfg.ackAll || (cfg.remoteAutoAck && match));
         aliasHit <= txnValid && match;
         if (txnValid) begin
            // Direction bit is carried over unchanged
            fwdAddr <= match ? {cfg.targetAddr, txnAddr[bcc_cfg_pkg::BIT_RW]} : txnAddr;
         end
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   chk_zero_alias: assert property (
      txnValid && cfg.aliasAddr == 7'h00 |=> !aliasHit)
      else $error("zero alias decoded as match");
   chk_remap_target: assert property (
      txnValid && match |=> fwdAddr[7:1] == $past(cfg.targetAddr))
      else $error("matched address not remapped");
   chk_dir_kept: assert property (
      txnValid |=> fwdAddr[0] == $past(txnAddr[0]))
      else $error("direction bit changed");
   chk_ack_all: assert property (
      txnValid && !txnAddr[0] && cfg.ackAll |=> localAck)
      else $error("write not acknowledged locally");
   chk_pass_all: assert property (
      txnValid && cfg.passAll |=> fwdValid)
      else $error("pass-all transaction not forwarded");
   chk_match_only: assert property (
      txnValid && !cfg.passAll && !match |=> !fwdValid)
      else $error("unmatched transaction forwarded");

   cov_remap: cover property (txnValid && match && cfg.passMatch ##1 fwdValid);
   cov_autoack: cover property (txnValid && match && cfg.remoteAutoAck ##1 localAck);

endmodule

`default_nettype wire

// ---- src/back_channel_i2c_forward_config.sv ----
`timescale 1ns/10ps
`default_nettype none

module back_channel_i2c_forward_config (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Local host register access
   input wire logic locWrite,
   input wire logic locRead,
   input wire logic [7:0] locAddr,
   input wire logic [7:0] locWdata,
   output logic [7:0] regRdata,
   // Remote register writes over the control channel
   input wire logic remWrite,
   input wire logic [7:0] remAddr,
   input wire logic [7:0] remWdata,
   // Forward channel loads
   input wire logic fcDatapathValid,
   input wire logic [1:0] fcGpioCount,
   input wire logic fcIdValid,
   input wire logic [6:0] fcId,
   // Power-down pin and straps
   input wire logic power_down_bar_pin,
   input wire logic [2:0] rateStrap,
   // Transactions from local host
   input wire logic txnValid,
   input wire logic [7:0] txnAddr,
   // Forward decision
   output logic fwdValid,
   output logic [7:0] fwdAddr,
   output logic localAck,
   output logic aliasHit,
   // Return link controls
   output logic returnLinkEnable,
   output logic return_link_crc_gen_en,
   output logic [2:0] return_link_rate_sel,
   output bcc_cfg_pkg::rate_t returnLinkRate,
   output logic [1:0] inbound_gpio_count
);

   // ------------------------------------------------------------
   // Register state
   // ------------------------------------------------------------
   logic passAll;
   logic passMatch;
   logic ackAll;
   logic return_link_force_on;
   logic block_remote_load;
   logic [6:0] remote_device_identity;
   logic hold_remote_identity;
   logic [6:0] remote_alias_addr;
   logic remote_write_autoack;
   logic [6:0] far_target_addr0;
   logic powerPinPrev;

   // Local access wins a same-cycle collision; the remote write is lost
   logic anyWrite;
   logic fromLocal;
   logic [7:0] wAddr;
   logic [7:0] wData;

   assign anyWrite = locWrite || remWrite;
   assign fromLocal = locWrite;
   assign wAddr = locWrite ? locAddr : remAddr;
   assign wData = locWrite ? locWdata : remWdata;

   function automatic logic regHit(input logic en, input logic [7:0] addr, input logic [7:0] off);
      regHit = en && (addr == off);
   endfunction

   logic wrConfig;
   logic wrDatapath;
   logic wrIdentity;
   logic wrAlias;
   logic wrTarget;

   assign wrConfig = regHit(anyWrite, wAddr, bcc_cfg_pkg::OFF_BACK_CHANNEL_CONFIG);
   assign wrDatapath = regHit(anyWrite, wAddr, bcc_cfg_pkg::OFF_DATAPATH_CONTROL_ONE);
   assign wrIdentity = regHit(anyWrite, wAddr, bcc_cfg_pkg::OFF_REMOTE_DEVICE_IDENTITY);
   assign wrAlias = regHit(anyWrite, wAddr, bcc_cfg_pkg::OFF_REMOTE_ALIAS_DECODE);
   assign wrTarget = regHit(anyWrite, wAddr, bcc_cfg_pkg::OFF_FAR_TARGET_ADDRESS_0);

   // ------------------------------------------------------------
   // Back channel configuration
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         passAll <= bcc_cfg_pkg::RST_PASS_ALL;
         passMatch <= bcc_cfg_pkg::RST_PASS_MATCH;
         ackAll <= bcc_cfg_pkg::RST_ACK_ALL;
         return_link_crc_gen_en <= bcc_cfg_pkg::RST_CRC_EN;
      end else if (wrConfig) begin
         passAll <= wData[bcc_cfg_pkg::BIT_PASS_ALL];
         passMatch <= wData[bcc_cfg_pkg::BIT_PASS_MATCH];
         ackAll <= wData[bcc_cfg_pkg::BIT_ACK_ALL];
         return_link_crc_gen_en <= wData[bcc_cfg_pkg::BIT_CRC_EN];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         return_link_force_on <= bcc_cfg_pkg::RST_FORCE_ON;
      end else if (wrConfig && fromLocal) begin
         return_link_force_on <= wData[bcc_cfg_pkg::BIT_FORCE_ON];
      end
   end

   // Pin rise detected against its registered copy; the strap is caught on the clock after its rise
   always_ff @(posedge clk) begin
      if (rst) begin
         powerPinPrev <= 1'b0;
      end else begin
         powerPinPrev <= power_down_bar_pin;
      end
   end

   // Remote rate changes may corrupt traffic briefly; the far side copes
   always_ff @(posedge clk) begin
      if (rst) begin
         return_link_rate_sel <= bcc_cfg_pkg::RST_RATE;
      end else if (power_down_bar_pin && !powerPinPrev) begin
         return_link_rate_sel <= rateStrap;
      end else if (wrConfig) begin
         return_link_rate_sel <= wData[bcc_cfg_pkg::RATE_MSB:0];
      end
   end

   assign returnLinkRate = bcc_cfg_pkg::decode_rate(return_link_rate_sel);
   assign returnLinkEnable = return_link_force_on || passAll || passMatch;

   // ------------------------------------------------------------
   // Datapath control
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         block_remote_load <= bcc_cfg_pkg::RST_FLAG;
      end else if (wrDatapath) begin
         block_remote_load <= wData[bcc_cfg_pkg::BIT_BLOCK_LOAD];
      end
   end

   // Write gate uses the stored block bit, not the one in the same write
   always_ff @(posedge clk) begin
      if (rst) begin
         inbound_gpio_count <= bcc_cfg_pkg::RST_GPIO;
      end else if (wrDatapath && block_remote_load) begin
         inbound_gpio_count <= wData[bcc_cfg_pkg::GPIO_MSB:0];
      end else if (fcDatapathValid && !block_remote_load) begin
         inbound_gpio_count <= fcGpioCount;
      end
   end

   // ------------------------------------------------------------
   // Remote identity, alias and target
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         remote_device_identity <= bcc_cfg_pkg::RST_ADDR7;
         hold_remote_identity <= bcc_cfg_pkg::RST_FLAG;
      end else if (wrIdentity) begin
         remote_device_identity <= wData[bcc_cfg_pkg::ADDR_MSB:bcc_cfg_pkg::ADDR_LSB];
         hold_remote_identity <= wData[bcc_cfg_pkg::BIT_HOLD_ID];
      end else if (fcIdValid && !hold_remote_identity) begin
         remote_device_identity <= fcId;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         remote_alias_addr <= bcc_cfg_pkg::RST_ADDR7;
         remote_write_autoack <= bcc_cfg_pkg::RST_FLAG;
      end else if (wrAlias) begin
         remote_alias_addr <= wData[bcc_cfg_pkg::ADDR_MSB:bcc_cfg_pkg::ADDR_LSB];
         remote_write_autoack <= wData[bcc_cfg_pkg::BIT_AUTOACK];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         far_target_addr0 <= bcc_cfg_pkg::RST_ADDR7;
      end else if (wrTarget) begin
         far_target_addr0 <= wData[bcc_cfg_pkg::ADDR_MSB:bcc_cfg_pkg::ADDR_LSB];
      end
   end

   // ------------------------------------------------------------
   // Read-back
   // ------------------------------------------------------------
   logic [7:0] next_regRdata;

   always_comb begin
      next_regRdata = bcc_cfg_pkg::RST_RDATA;
      unique case (locAddr)
         bcc_cfg_pkg::OFF_BACK_CHANNEL_CONFIG:
            next_regRdata = {passAll, passMatch, ackAll, return_link_force_on,
                             return_link_crc_gen_en, return_link_rate_sel};
         bcc_cfg_pkg::OFF_DATAPATH_CONTROL_ONE:
            next_regRdata = {block_remote_load, 5'h00, inbound_gpio_count};
         bcc_cfg_pkg::OFF_REMOTE_DEVICE_IDENTITY:
            next_regRdata = {remote_device_identity, hold_remote_identity};
         bcc_cfg_pkg::OFF_REMOTE_ALIAS_DECODE:
            next_regRdata = {remote_alias_addr, remote_write_autoack};
         bcc_cfg_pkg::OFF_FAR_TARGET_ADDRESS_0:
            next_regRdata = {far_target_addr0, 1'b0};
         default:
            next_regRdata = bcc_cfg_pkg::RST_RDATA;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         regRdata <= bcc_cfg_pkg::RST_RDATA;
      end else if (locRead) begin
         regRdata <= next_regRdata;
      end
   end

   // ------------------------------------------------------------
   // Address decode and remap
   // ------------------------------------------------------------
   fwd_cfg_if cfg ();

   assign cfg.passAll = passAll;
   assign cfg.passMatch = passMatch;
   assign cfg.ackAll = ackAll;
   assign cfg.remoteAutoAck = remote_write_autoack;
   assign cfg.aliasAddr = remote_alias_addr;
   assign cfg.targetAddr = far_target_addr0;

   addr_forward_decode decode (
      .clk(clk),
      .rst(rst),
      .cfg(cfg),
      .txnValid(txnValid),
      .txnAddr(txnAddr),
      .fwdValid(fwdValid),
      .fwdAddr(fwdAddr),
      .localAck(localAck),
      .aliasHit(aliasHit)
   );

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   chk_force_on_local: assert property (
      remWrite && !locWrite && remAddr == 8'h58 |=> $stable(return_link_force_on))
      else $error("remote write changed force-on");
   chk_link_enable: assert property (
      locWrite && locAddr == 8'h58 |=>
      returnLinkEnable == ($past(locWdata[7]) || $past(locWdata[6]) || $past(locWdata[4])))
      else $error("return link enable wrong after config write");
   chk_crc_follow: assert property (
      anyWrite && wAddr == 8'h58 |=> return_link_crc_gen_en == $past(wData[3]))
      else $error("crc enable not following write");
   chk_strap_capture: assert property (
      power_down_bar_pin && !powerPinPrev |=> return_link_rate_sel == $past(rateStrap))
      else $error("strap not captured on pin rise");
   chk_gpio_guard: assert property (
      wrDatapath && !block_remote_load && !fcDatapathValid |=> $stable(inbound_gpio_count))
      else $error("gpio count written while not blocked");
   chk_fc_blocked: assert property (
      block_remote_load && fcDatapathValid && !wrDatapath |=> $stable(inbound_gpio_count))
      else $error("gpio count loaded while blocked");
   chk_id_freeze: assert property (
      hold_remote_identity && fcIdValid && !wrIdentity |=> $stable(remote_device_identity))
      else $error("frozen identity changed");
   chk_id_load: assert property (
      !hold_remote_identity && fcIdValid && !wrIdentity |=> remote_device_identity == $past(fcId))
      else $error("identity not auto-loaded");
   chk_read_reserved: assert property (
      locRead && locAddr == 8'h5A |=> regRdata == 8'h00)
      else $error("reserved register reads nonzero");

   cov_strap: cover property (power_down_bar_pin && !powerPinPrev);
   cov_fc_load: cover property (fcDatapathValid && !block_remote_load ##1 inbound_gpio_count != 2'h0);
   cov_link_off: cover property (!returnLinkEnable);

endmodule

`default_nettype wire

// ---- sim/remote_ser_model.sv ----
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------
// Remote serializer side of the control channel
// ----------------------------------------
module remote_ser_model (
   // Clock
   input wire logic clk,
   // Remote register writes
   output logic remWrite,
   output logic [7:0] remAddr,
   output logic [7:0] remWdata,
   // Forward channel loads
   output logic fcDatapathValid,
   output logic [1:0] fcGpioCount,
   output logic fcIdValid,
   output logic [6:0] fcId
);
   initial begin
      remWrite = 1'b0;
      remAddr = 8'h00;
      remWdata = 8'h00;
      fcDatapathValid = 1'b0;
      fcGpioCount = 2'h0;
      fcIdValid = 1'b0;
      fcId = 7'h00;
   end

   // Stale data is inverted, so a late sample cannot pass by luck
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      remWrite <= 1'b1;
      remAddr <= a;
      remWdata <= d;
      @(posedge clk);
      remWrite <= 1'b0;
      remWdata <= ~d;
   endtask

   // Ack-all goes on first, so a garbled return link cannot stall the host
   task automatic set_rate(input logic [7:0] base, input logic [2:0] code);
      wr(8'h58, base | 8'h20);
      wr(8'h58, base | 8'h20 | {5'h00, code});
   endtask

   task automatic load(input logic [1:0] g, input logic gv, input logic [6:0] id, input logic iv);
      @(posedge clk);
      fcDatapathValid <= gv;
      fcGpioCount <= g;
      fcIdValid <= iv;
      fcId <= id;
      @(posedge clk);
      fcDatapathValid <= 1'b0;
      fcGpioCount <= ~g;
      fcIdValid <= 1'b0;
      fcId <= ~id;
   endtask
endmodule

`default_nettype wire

// ---- sim/back_channel_i2c_forward_config_tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none

module back_channel_i2c_forward_config_tb_top;
   logic clk;
   logic rst;
   logic locWrite;
   logic locRead;
   logic [7:0] locAddr;
   logic [7:0] locWdata;
   logic [7:0] regRdata;
   logic remWrite;
   logic [7:0] remAddr;
   logic [7:0] remWdata;
   logic fcDatapathValid;
   logic [1:0] fcGpioCount;
   logic fcIdValid;
   logic [6:0] fcId;
   logic power_down_bar_pin;
   logic [2:0] rateStrap;
   logic txnValid;
   logic [7:0] txnAddr;
   logic fwdValid;
   logic [7:0] fwdAddr;
   logic localAck;
   logic aliasHit;
   logic returnLinkEnable;
   logic return_link_crc_gen_en;
   logic [2:0] return_link_rate_sel;
   bcc_cfg_pkg::rate_t returnLinkRate;
   logic [1:0] inbound_gpio_count;
   int fails = 0;
   int comparisons = 0;
   int seed = 32'hB853CC6C;
   logic [7:0] c;
   logic [7:0] al;
   logic [7:0] t;
   logic [7:0] x;
   logic [7:0] cfgs [5] = '{8'h00, 8'h08, 8'h80, 8'h40, 8'h10};

   back_channel_i2c_forward_config back_channel_i2c_forward_config_i (.clk(clk), .rst(rst),
      .locWrite(locWrite), .locRead(locRead), .locAddr(locAddr), .locWdata(locWdata), .regRdata(regRdata),
      .remWrite(remWrite), .remAddr(remAddr), .remWdata(remWdata), .fcDatapathValid(fcDatapathValid),
      .fcGpioCount(fcGpioCount), .fcIdValid(fcIdValid), .fcId(fcId), .power_down_bar_pin(power_down_bar_pin),
      .rateStrap(rateStrap), .txnValid(txnValid), .txnAddr(txnAddr), .fwdValid(fwdValid), .fwdAddr(fwdAddr),
      .localAck(localAck), .aliasHit(aliasHit), .returnLinkEnable(returnLinkEnable),
      .return_link_crc_gen_en(return_link_crc_gen_en), .return_link_rate_sel(return_link_rate_sel),
      .returnLinkRate(returnLinkRate), .inbound_gpio_count(inbound_gpio_count));

   remote_ser_model remote_ser_model_i (.clk(clk), .remWrite(remWrite), .remAddr(remAddr), .remWdata(remWdata),
      .fcDatapathValid(fcDatapathValid), .fcGpioCount(fcGpioCount), .fcIdValid(fcIdValid), .fcId(fcId));

   // ----------------------------------------
   // Bench helpers
   // ----------------------------------------
   task automatic give_verdict;
      $display("fails=%0d comparisons=%0d", fails, comparisons);
      if (fails == 0 && comparisons > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic lw(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      locWrite <= 1'b1;
      locAddr <= a;
      locWdata <= d;
      @(posedge clk);
      locWrite <= 1'b0;
      locWdata <= ~d;
   endtask

   task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      locRead <= 1'b1;
      locAddr <= a;
      @(posedge clk);
      locRead <= 1'b0;
      #1;
      cmp(regRdata, exp);
   endtask

   function automatic bcc_cfg_pkg::rate_t exp_rate(input logic [2:0] code);
      case (code)
         3'h0: return bcc_cfg_pkg::RATE_2M5;
         3'h2: return bcc_cfg_pkg::RATE_10M;
         3'h5: return bcc_cfg_pkg::RATE_25M;
         3'h6: return bcc_cfg_pkg::RATE_50M;
         3'h7: return bcc_cfg_pkg::RATE_100M;
         default: return bcc_cfg_pkg::RATE_RESERVED;
      endcase
   endfunction

   // Expected decision is built from the raw register bytes only
   task automatic txn(input logic [7:0] xa, input logic [7:0] cf, input logic [7:0] ali, input logic [7:0] tg);
      logic m;
      m = (ali[7:1] != 7'h00) && (xa[7:1] == ali[7:1]);
      @(posedge clk);
      txnValid <= 1'b1;
      txnAddr <= xa;
      @(posedge clk);
      txnValid <= 1'b0;
      txnAddr <= ~xa;
      #1;
      cmp({7'h00, fwdValid}, {7'h00, cf[7] | (cf[6] & m)});
      cmp(fwdAddr, m ? {tg[7:1], xa[0]} : xa);
      cmp({7'h00, localAck}, {7'h00, ~xa[0] & (cf[5] | (ali[0] & m))});
      cmp({7'h00, aliasHit}, {7'h00, m});
   endtask

   // ----------------------------------------
   // Clock, watchdog and main sequence
   // ----------------------------------------
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   initial begin
      repeat (20000) @(posedge clk);
      fails++;
      give_verdict;
   end

   initial begin
      rst = 1'b1;
      locWrite = 1'b0;
      locRead = 1'b0;
      locAddr = 8'h00;
      locWdata = 8'h00;
      txnValid = 1'b0;
      txnAddr = 8'h00;
      power_down_bar_pin = 1'b0;
      rateStrap = 3'h6;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      rchk(8'h58, 8'h18);
      for (int a = 8'h59; a <= 8'h5E; a++) begin
         rchk(a[7:0], 8'h00);
      end
      @(posedge clk);
      power_down_bar_pin <= 1'b1;
      rchk(8'h58, 8'h1E);
      for (int i = 0; i < 8; i++) begin
         lw(8'h58, 8'h18 | i[7:0]);
         @(negedge clk);
         cmp({5'h00, return_link_rate_sel}, i[7:0]);
         cmp({2'h0, returnLinkRate}, {2'h0, exp_rate(i[2:0])});
      end
      foreach (cfgs[k]) begin
         lw(8'h58, cfgs[k]);
         @(negedge clk);
         cmp({7'h00, returnLinkEnable}, {7'h00, cfgs[k][4] | cfgs[k][7] | cfgs[k][6]});
         cmp({7'h00, return_link_crc_gen_en}, {7'h00, cfgs[k][3]});
      end
      lw(8'h58, 8'h18);
      remote_ser_model_i.set_rate(8'h00, 3'h5);
      rchk(8'h58, 8'h35);
      lw(8'h58, 8'h08);
      remote_ser_model_i.set_rate(8'h10, 3'h2);
      rchk(8'h58, 8'h22);
      remote_ser_model_i.load(2'h2, 1'b1, 7'h00, 1'b0);
      rchk(8'h59, 8'h02);
      lw(8'h59, 8'h03);
      rchk(8'h59, 8'h02);
      lw(8'h59, 8'h83);
      rchk(8'h59, 8'h82);
      lw(8'h59, 8'hFF);
      rchk(8'h59, 8'h83);
      remote_ser_model_i.load(2'h1, 1'b1, 7'h00, 1'b0);
      rchk(8'h59, 8'h83);
      cmp({6'h00, inbound_gpio_count}, 8'h03);
      remote_ser_model_i.load(2'h0, 1'b0, 7'h55, 1'b1);
      rchk(8'h5B, 8'hAA);
      lw(8'h5B, 8'h67);
      remote_ser_model_i.load(2'h0, 1'b0, 7'h11, 1'b1);
      rchk(8'h5B, 8'h67);
      fork
         lw(8'h5D, 8'h43);
         remote_ser_model_i.wr(8'h5D, 8'h24);
      join
      rchk(8'h5D, 8'h42);
      for (int n = 0; n < 60; n++) begin
         c = 8'($random(seed));
         al = 8'($random(seed));
         t = 8'($random(seed));
         x = 8'($random(seed));
         if (n % 8 == 0) begin
            al[7:1] = 7'h00;
         end
         if (n % 2 == 1) begin
            x[7:1] = al[7:1];
         end
         lw(8'h58, c);
         lw(8'h5C, al);
         lw(8'h5D, t);
         txn(x, c, al, t);
         txn(x ^ 8'h01, c, al, t);
      end
      // Second reset with a fresh strap; the pin must rise again before it loads
      @(posedge clk);
      rst <= 1'b1;
      power_down_bar_pin <= 1'b0;
      rateStrap <= 3'($random(seed));
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      rchk(8'h58, 8'h18);
      @(posedge clk);
      power_down_bar_pin <= 1'b1;
      rchk(8'h58, {5'h03, rateStrap});
      give_verdict;
   end
endmodule

`default_nettype wire
